/* File: design/sdrc_regs.svh */
`ifndef SDRC_REGS_SVH
`define SDRC_REGS_SVH

// register addresses on the serial control interface
`define SDRC_ADDR_WIDTH 12
`define SDRC_OUT0_LOWRATE_PREEMPHASIS_ADDR 12'h02a
`define SDRC_OUT0_LOWRATE_SWING_ADDR 12'h02b

// reset values of whole registers
`define SDRC_OUT0_LOWRATE_PREEMPHASIS_RST 16'h0340
`define SDRC_OUT0_LOWRATE_SWING_RST 16'h17a0

// first register fields
`define SDRC_EMPH_WIDTH_MSB 12
`define SDRC_EMPH_WIDTH_LSB 8
`define SDRC_EMPH_OFF_BIT 6
`define SDRC_EMPH_LEVEL_MSB 5
`define SDRC_EMPH_LEVEL_LSB 0
`define SDRC_EMPH_RSVD_HI_MSB 15
`define SDRC_EMPH_RSVD_HI_LSB 13
`define SDRC_EMPH_RSVD_MID_BIT 7

// first register field reset values
`define SDRC_EMPH_RSVD_HI_RST 3'h0
`define SDRC_EMPH_WIDTH_RST 5'h03
`define SDRC_EMPH_RSVD_MID_RST 1'h0
`define SDRC_EMPH_OFF_RST 1'h1
`define SDRC_EMPH_LEVEL_RST 6'h00

// second register fields
`define SDRC_SWING_LEVEL_MSB 13
`define SDRC_SWING_LEVEL_LSB 8
`define SDRC_SWING_RSVD_HI_MSB 15
`define SDRC_SWING_RSVD_HI_LSB 14
`define SDRC_SWING_RSVD_LO_MSB 7
`define SDRC_SWING_RSVD_LO_LSB 0

// second register field reset values
`define SDRC_SWING_RSVD_HI_RST 2'h0
`define SDRC_SWING_LEVEL_RST 6'h17
`define SDRC_SWING_RSVD_LO_RST 8'ha0

`define SDRC_READ_UNMAPPED 16'h0000

`endif

/* File: design/sdrc_pkg.sv */
package sdrc_pkg;

  // rate at which the recovery loop reports lock
  typedef enum logic [1:0] {
    sdrc_rate_madi,
    sdrc_rate_sd,
    sdrc_rate_hd,
    sdrc_rate_3g
  } sdrc_rate_t;

  // slew setting handed to the output 0 driver
  typedef enum logic [2:0] {
    sdrc_slew_bypass,
    sdrc_slew_madi,
    sdrc_slew_sd,
    sdrc_slew_hd,
    sdrc_slew_3g
  } sdrc_slew_t;

  typedef logic [15:0] sdrc_word_t;

endpackage : sdrc_pkg

/* File: design/sdrc_slew_select.sv */
`timescale 1ns/1ps
module sdrc_slew_select (
  // selection inputs
  input wire logic auto_slew,
  input wire logic cdr_locked,
  input wire sdrc_pkg::sdrc_rate_t cdr_rate,
  input wire sdrc_pkg::sdrc_slew_t manual_slew,
  // chosen setting, combinational
  output sdrc_pkg::sdrc_slew_t slew_choice
);

  function automatic sdrc_pkg::sdrc_slew_t rate_to_slew(input sdrc_pkg::sdrc_rate_t rate);
    case (rate)
      sdrc_pkg::sdrc_rate_madi: rate_to_slew = sdrc_pkg::sdrc_slew_madi;
      sdrc_pkg::sdrc_rate_sd: rate_to_slew = sdrc_pkg::sdrc_slew_sd;
      sdrc_pkg::sdrc_rate_hd: rate_to_slew = sdrc_pkg::sdrc_slew_hd;
      sdrc_pkg::sdrc_rate_3g: rate_to_slew = sdrc_pkg::sdrc_slew_3g;
      default: rate_to_slew = sdrc_pkg::sdrc_slew_bypass;
    endcase
  endfunction : rate_to_slew

  always_comb begin
    if (!auto_slew) begin
      slew_choice = manual_slew;
    end else if (!cdr_locked) begin
      slew_choice = sdrc_pkg::sdrc_slew_bypass;
    end else begin
      slew_choice = rate_to_slew(cdr_rate);
    end
  end

endmodule : sdrc_slew_select

/* File: design/sdrc_out0_lowrate_cfg.sv */
// Operation
// - five-bit emphasis width at 12:8 of first register, reset 3, range 0-15.
// - bit 6 of first register, reset 1, powers down pre-emphasis.
// - six-bit emphasis level at 5:0 of first register, reset 0, range 0-15.
// - six-bit swing level at 13:8 of second register, reset hex 17.
// - with auto slew set, slew follows the locked recovery rate.
// - auto slew with recovery unlocked drives bypass slew.
`timescale 1ns/1ps
`include "sdrc_regs.svh"
module sdrc_out0_lowrate_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access from the serial control interface
  input wire logic [`SDRC_ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rdata_valid,
  // slew control and recovery loop status
  input wire logic out0_auto_slew_select,
  input wire logic cdr_locked,
  input wire sdrc_pkg::sdrc_rate_t cdr_rate,
  input wire sdrc_pkg::sdrc_slew_t manual_slew,
  // output 0 driver controls
  output logic [4:0] out0_lowrate_emph_width,
  output logic out0_lowrate_emph_off,
  output logic [5:0] out0_lowrate_emph_level,
  output logic [5:0] out0_lowrate_swing_level,
  output sdrc_pkg::sdrc_slew_t out0_slew
);

  // first register, one flop group per field
  logic [2:0] emph_rsvd_hi_reg;
  logic [2:0] emph_rsvd_hi_next;
  logic [4:0] emph_width_reg;
  logic [4:0] emph_width_next;
  logic emph_rsvd_mid_reg;
  logic emph_rsvd_mid_next;
  logic emph_off_reg;
  logic emph_off_next;
  logic [5:0] emph_level_reg;
  logic [5:0] emph_level_next;

  // second register
  logic [1:0] swing_rsvd_hi_reg;
  logic [1:0] swing_rsvd_hi_next;
  logic [5:0] swing_level_reg;
  logic [5:0] swing_level_next;
  logic [7:0] swing_rsvd_lo_reg;
  logic [7:0] swing_rsvd_lo_next;

  // read port and slew
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  sdrc_pkg::sdrc_slew_t slew_reg;
  sdrc_pkg::sdrc_slew_t slew_next;
  sdrc_pkg::sdrc_slew_t slew_choice;

  function automatic logic addr_hit(input logic [`SDRC_ADDR_WIDTH-1:0] a,
                                    input logic [`SDRC_ADDR_WIDTH-1:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  function automatic sdrc_pkg::sdrc_word_t pack_preemphasis(
      input logic [2:0] rsvd_hi,
      input logic [4:0] width,
      input logic rsvd_mid,
      input logic off,
      input logic [5:0] level);
    pack_preemphasis = {rsvd_hi, width, rsvd_mid, off, level};
  endfunction : pack_preemphasis

  function automatic sdrc_pkg::sdrc_word_t pack_swing(
      input logic [1:0] rsvd_hi,
      input logic [5:0] level,
      input logic [7:0] rsvd_lo);
    pack_swing = {rsvd_hi, level, rsvd_lo};
  endfunction : pack_swing

  // first register write path
  always_comb begin
    emph_rsvd_hi_next = emph_rsvd_hi_reg;
    emph_width_next = emph_width_reg;
    emph_rsvd_mid_next = emph_rsvd_mid_reg;
    emph_off_next = emph_off_reg;
    emph_level_next = emph_level_reg;
    if (reg_wr && addr_hit(reg_addr, `SDRC_OUT0_LOWRATE_PREEMPHASIS_ADDR)) begin
      emph_rsvd_hi_next = reg_wdata[`SDRC_EMPH_RSVD_HI_MSB:`SDRC_EMPH_RSVD_HI_LSB];
      emph_width_next = reg_wdata[`SDRC_EMPH_WIDTH_MSB:`SDRC_EMPH_WIDTH_LSB];
      emph_rsvd_mid_next = reg_wdata[`SDRC_EMPH_RSVD_MID_BIT];
      emph_off_next = reg_wdata[`SDRC_EMPH_OFF_BIT];
      emph_level_next = reg_wdata[`SDRC_EMPH_LEVEL_MSB:`SDRC_EMPH_LEVEL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      emph_rsvd_hi_reg <= `SDRC_EMPH_RSVD_HI_RST;
      emph_width_reg <= `SDRC_EMPH_WIDTH_RST;
      emph_rsvd_mid_reg <= `SDRC_EMPH_RSVD_MID_RST;
      emph_off_reg <= `SDRC_EMPH_OFF_RST;
      emph_level_reg <= `SDRC_EMPH_LEVEL_RST;
    end else begin
      emph_rsvd_hi_reg <= emph_rsvd_hi_next;
      emph_width_reg <= emph_width_next;
      emph_rsvd_mid_reg <= emph_rsvd_mid_next;
      emph_off_reg <= emph_off_next;
      emph_level_reg <= emph_level_next;
    end
  end

  // second register write path
  always_comb begin
    swing_rsvd_hi_next = swing_rsvd_hi_reg;
    swing_level_next = swing_level_reg;
    swing_rsvd_lo_next = swing_rsvd_lo_reg;
    if (reg_wr && addr_hit(reg_addr, `SDRC_OUT0_LOWRATE_SWING_ADDR)) begin
      swing_rsvd_hi_next = reg_wdata[`SDRC_SWING_RSVD_HI_MSB:`SDRC_SWING_RSVD_HI_LSB];
      swing_level_next = reg_wdata[`SDRC_SWING_LEVEL_MSB:`SDRC_SWING_LEVEL_LSB];
      swing_rsvd_lo_next = reg_wdata[`SDRC_SWING_RSVD_LO_MSB:`SDRC_SWING_RSVD_LO_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swing_rsvd_hi_reg <= `SDRC_SWING_RSVD_HI_RST;
      swing_level_reg <= `SDRC_SWING_LEVEL_RST;
      // low byte resets to hex a0
      swing_rsvd_lo_reg <= `SDRC_SWING_RSVD_LO_RST;
    end else begin
      swing_rsvd_hi_reg <= swing_rsvd_hi_next;
      swing_level_reg <= swing_level_next;
      swing_rsvd_lo_reg <= swing_rsvd_lo_next;
    end
  end

  // read path; a read in the same cycle as a write returns the old value
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_rd) begin
      rvalid_next = 1'b1;
      if (addr_hit(reg_addr, `SDRC_OUT0_LOWRATE_PREEMPHASIS_ADDR)) begin
        rdata_next = pack_preemphasis(emph_rsvd_hi_reg, emph_width_reg,
                                      emph_rsvd_mid_reg, emph_off_reg, emph_level_reg);
      end else if (addr_hit(reg_addr, `SDRC_OUT0_LOWRATE_SWING_ADDR)) begin
        rdata_next = pack_swing(swing_rsvd_hi_reg, swing_level_reg, swing_rsvd_lo_reg);
      end else begin
        rdata_next = `SDRC_READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `SDRC_READ_UNMAPPED;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  sdrc_slew_select u_slew_select (
    .auto_slew(out0_auto_slew_select),
    .cdr_locked(cdr_locked),
    .cdr_rate(cdr_rate),
    .manual_slew(manual_slew),
    .slew_choice(slew_choice)
  );

  // slew next value
  always_comb begin
    slew_next = slew_choice;
  end

  // slew registered so the driver control comes from a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slew_reg <= sdrc_pkg::sdrc_slew_bypass;
    end else begin
      slew_reg <= slew_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rdata_valid = rvalid_reg;
  // fields are passed unclamped; out-of-range values are software's to avoid
  // fields drive output 0
  assign out0_lowrate_emph_width = emph_width_reg;
  assign out0_lowrate_emph_off = emph_off_reg;
  assign out0_lowrate_emph_level = emph_level_reg;
  assign out0_lowrate_swing_level = swing_level_reg;
  assign out0_slew = slew_reg;

endmodule : sdrc_out0_lowrate_cfg

/* File: test/sdrc_out0_monitor.sv */
`timescale 1ns/1ps
module sdrc_out0_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rdata_valid,
  // slew
  input wire logic out0_auto_slew_select,
  input wire logic cdr_locked,
  input wire sdrc_pkg::sdrc_rate_t cdr_rate,
  input wire sdrc_pkg::sdrc_slew_t out0_slew,
  // driver fields
  input wire logic [4:0] out0_lowrate_emph_width,
  input wire logic out0_lowrate_emph_off,
  input wire logic [5:0] out0_lowrate_emph_level,
  input wire logic [5:0] out0_lowrate_swing_level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire w2a = reg_wr && reg_addr == 12'h02a;
  wire w2b = reg_wr && reg_addr == 12'h02b;
  wire lk = out0_auto_slew_select && cdr_locked;
  AST_WIDTH: assert property (w2a |=> out0_lowrate_emph_width == $past(reg_wdata[12:8]))
    else $error("bad width");
  AST_OFF: assert property (w2a |=> out0_lowrate_emph_off == $past(reg_wdata[6]))
    else $error("bad off");
  AST_LEVEL: assert property (w2a |=> out0_lowrate_emph_level == $past(reg_wdata[5:0]))
    else $error("bad level");
  AST_SWING: assert property (w2b |=> out0_lowrate_swing_level == $past(reg_wdata[13:8]))
    else $error("bad swing");
  AST_AUTO: assert property (lk |=> out0_slew == {1'b0, $past(cdr_rate)} + 3'h1)
    else $error("bad auto slew");
  AST_BYPASS: assert property (out0_auto_slew_select && !cdr_locked |=> out0_slew == 3'h0)
    else $error("bad bypass");
  AST_RDVALID: assert property (reg_rd |=> reg_rdata_valid ##1 (!reg_rdata_valid || $past(reg_rd)))
    else $error("bad valid");
  AST_HOLD: assert property (!reg_wr |=> $stable(out0_lowrate_swing_level))
    else $error("swing moved");
  COV_WR: cover property (w2a);
  COV_LK: cover property (lk);
  COV_RD: cover property (reg_rd);
endmodule : sdrc_out0_monitor

bind sdrc_out0_lowrate_cfg sdrc_out0_monitor sdrc_out0_monitor_i (.*);

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic out0_auto_slew_select = 0, cdr_locked = 0, reg_rdata_valid, out0_lowrate_emph_off;
  logic [11:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [4:0] out0_lowrate_emph_width;
  logic [5:0] out0_lowrate_emph_level, out0_lowrate_swing_level;
  sdrc_pkg::sdrc_rate_t cdr_rate = sdrc_pkg::sdrc_rate_madi;
  sdrc_pkg::sdrc_slew_t manual_slew = sdrc_pkg::sdrc_slew_bypass, out0_slew;
  int mismatches = 0, num_checks = 0;
  sdrc_out0_lowrate_cfg sdrc_out0_lowrate_cfg_i (.*);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0, reg_rdata_valid}, 16'h1);
    chk(reg_rdata, e);
    @(posedge clk);
    #1;
    chk({15'h0, reg_rdata_valid}, 16'h0);
  endtask : rd
  // packed view of the driver fields, reserved places zero
  function automatic logic [15:0] emph();
    return {3'h0, out0_lowrate_emph_width, 1'b0, out0_lowrate_emph_off, out0_lowrate_emph_level};
  endfunction : emph
  task automatic t_reset;
    #1;
    chk(emph(), 16'h0340);
    chk({10'h0, out0_lowrate_swing_level}, 16'h0017);
    rd(12'h02a, 16'h0340);
    rd(12'h02b, 16'h17a0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_regs;
    wr(12'h02a, 16'h0f0f); // reserved bits kept at reset value
    #1;
    chk(emph(), 16'h0f0f);
    wr(12'h02b, 16'h09a0); // swing in range, reserved kept
    rd(12'h02a, 16'h0f0f);
    rd(12'h02b, 16'h09a0);
    chk({10'h0, out0_lowrate_swing_level}, 16'h0009);
    wr(12'h02c, 16'hffff);
    rd(12'h02c, 16'h0000);
    rd(12'h02b, 16'h09a0);
    $display("t_regs done");
  endtask : t_regs
  task automatic sl(input logic a, input logic l, input int r, input int e);
    @(posedge clk);
    out0_auto_slew_select <= a;
    cdr_locked <= l;
    cdr_rate <= sdrc_pkg::sdrc_rate_t'(r);
    manual_slew <= sdrc_pkg::sdrc_slew_hd;
    repeat (2) @(posedge clk);
    #1;
    chk({13'h0, out0_slew}, e[15:0]);
  endtask : sl
  task automatic t_slew;
    for (int r = 0; r < 4; r++) sl(1'b1, 1'b1, r, r + 1);
    sl(1'b1, 1'b0, 3, 0);
    sl(1'b0, 1'b1, 0, 3);
    $display("t_slew done");
  endtask : t_slew
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_slew;
    stop_test;
  end
endmodule : tb_top
